//--- shared/skip_exec_cfg.svh
// Constants for the conditional-skip execution block.
// Assumes an 8-bit data memory and a two-cycle normal instruction time.
`ifndef SKIP_EXEC_CFG_SVH
`define SKIP_EXEC_CFG_SVH
`define DATA_WIDTH      8
`define BIT_SEL_WIDTH   3
`define ACCUM_RESET     8'h00
`define NORMAL_CYCLES   2
`define SKIP_CYCLES     3
`endif

//--- shared/skip_exec_pkg.sv
// Types for the conditional-skip execution block.
// Assumes the cfg header is on the include path.
`include "skip_exec_cfg.svh"
package skip_exec_pkg;
  typedef enum logic [1:0] {
    OP_INC_MEM_SKIP   = 2'h0,
    OP_INC_ACCUM_SKIP = 2'h1,
    OP_BIT_SKIP       = 2'h2
  } skip_op_e;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_EXEC  = 4'h2,
    ST_DUMMY = 4'h4,
    ST_DONE  = 4'h8
  } exec_state_e;
endpackage

//--- verilog/skip_cond_eval.sv
// Evaluates the increment result and the skip condition for one operand.
// Assumes operand and opcode are stable while it is read.
`timescale 1ns/1ns
`include "skip_exec_cfg.svh"
`default_nettype none
module skip_cond_eval
  import skip_exec_pkg::*;
#(
  parameter int WIDTH = `DATA_WIDTH
) (
  input  wire logic [WIDTH-1:0]          operand,
  input  wire logic [`BIT_SEL_WIDTH-1:0] bit_sel,
  input  wire skip_op_e                  op,
  output logic      [WIDTH-1:0]          inc_value,
  output logic                           skip
);
  // The bit index must reach every bit and no more
  if (WIDTH != (1 << `BIT_SEL_WIDTH)) begin : g_width_bad
    $error("Width must match bit select");
  end
  always_comb begin
    inc_value = operand + {{(WIDTH-1){1'b0}}, 1'b1};
    case (op)
      OP_INC_MEM_SKIP:   skip = (inc_value == '0);
      OP_INC_ACCUM_SKIP: skip = (inc_value == '0);
      OP_BIT_SKIP:       skip = operand[bit_sel];
      default:           skip = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- verilog/skip_exec.sv
// Execution unit for increment-and-skip and bit-test-skip instructions.
// Assumes decode gives a one-cycle start with the operand already read.
`timescale 1ns/1ns
`include "skip_exec_cfg.svh"
`default_nettype none
// Overview of operation
// - Increment-to-memory adds one and writes it back to the same byte.
// - An increment that yields zero skips the next instruction.
// - The accumulator variant loads byte plus one and tests that value.
// - The accumulator variant never writes data memory.
// - Bit-test skips the next instruction when the selected bit is one.
// - Bit-test with the selected bit zero runs the next instruction.
// - A taken skip adds a dummy cycle so the instruction takes three.
// - None of these instructions changes any status flag.
module skip_exec
  import skip_exec_pkg::*;
#(
  parameter int WIDTH = `DATA_WIDTH
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       start,
  input  wire skip_op_e                   op,
  input  wire logic [7:0]                 mem_addr,
  input  wire logic [WIDTH-1:0]           mem_rdata,
  input  wire logic [`BIT_SEL_WIDTH-1:0]  bit_sel,
  output logic                            busy,
  output logic                            mem_we,
  output logic      [7:0]                 mem_waddr,
  output logic      [WIDTH-1:0]           mem_wdata,
  output logic      [WIDTH-1:0]           accumulator_reg,
  output logic                            skip_next,
  output logic                            dummy_cycle,
  output logic                            flags_we,
  output logic                            done
);
  // ------------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------------
  logic [WIDTH-1:0] inc_value;
  logic             skip;
  exec_state_e      state_reg;
  logic [1:0]       cyc_reg;

  skip_cond_eval #(.WIDTH(WIDTH)) u_eval (
    .operand   (mem_rdata),
    .bit_sel   (bit_sel),
    .op        (op),
    .inc_value (inc_value),
    .skip      (skip)
  );

  // ------------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------------
  // Operands are sampled only in the start cycle; later ones are ignored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cyc_reg   <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_EXEC;
            cyc_reg   <= 2'h1;
          end
        end
        ST_EXEC: begin
          cyc_reg <= cyc_reg + 2'h1;
          if (skip_next) begin
            state_reg <= ST_DUMMY;
          end else begin
            state_reg <= ST_DONE;
          end
        end
        ST_DUMMY: begin
          cyc_reg   <= cyc_reg + 2'h1;
          state_reg <= ST_DONE;
        end
        ST_DONE: begin
          cyc_reg   <= 2'h0;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy        <= 1'b0;
      dummy_cycle <= 1'b0;
      done        <= 1'b0;
    end else begin
      busy        <= (state_reg == ST_IDLE) ? start : (state_reg != ST_DONE);
      dummy_cycle <= (state_reg == ST_EXEC) && skip_next;
      done        <= (state_reg == ST_EXEC && !skip_next)
                     || (state_reg == ST_DUMMY);
    end
  end

  // ------------------------------------------------------------------
  // Results
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_we    <= 1'b0;
      mem_waddr <= 8'h00;
      mem_wdata <= '0;
    end else begin
      mem_we <= 1'b0;
      if (state_reg == ST_IDLE && start && op == OP_INC_MEM_SKIP) begin
        mem_we    <= 1'b1;
        mem_waddr <= mem_addr;
        mem_wdata <= inc_value;
      end
      // Other operations never raise the write strobe
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      accumulator_reg <= `ACCUM_RESET;
    end else if (state_reg == ST_IDLE && start
                 && op == OP_INC_ACCUM_SKIP) begin
      accumulator_reg <= inc_value;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      skip_next <= 1'b0;
    end else if (state_reg == ST_IDLE && start) begin
      skip_next <= skip;
    end else if (state_reg == ST_DONE) begin
      skip_next <= 1'b0;
    end
  end

  // Flags stay untouched: the flag write enable is held low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_we <= 1'b0;
    end else begin
      flags_we <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_MEM_WB: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_IDLE && start && op == OP_INC_MEM_SKIP)
      |=> (mem_we && mem_wdata == $past(mem_rdata) + 8'h01))
    else $error("Increment not written back");
  AST_WE_PULSE: assert property (
    @(posedge clk_sys) disable iff (rst)
    mem_we |=> !mem_we)
    else $error("Write strobe longer than one cycle");
  AST_WADDR: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_IDLE && start && op == OP_INC_MEM_SKIP)
      |=> (mem_waddr == $past(mem_addr)))
    else $error("Write went to another byte");
  // Op code 3 is a no-op and must stay out of the zero test
  AST_ZERO_SKIP: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_IDLE && start
     && (op == OP_INC_MEM_SKIP || op == OP_INC_ACCUM_SKIP))
      |=> (skip_next == ($past(mem_rdata) == 8'hff)))
    else $error("Zero skip decision wrong");
  AST_SKIP_CLEAR: assert property (
    @(posedge clk_sys) disable iff (rst)
    done |=> !skip_next)
    else $error("Skip decision outlived its instruction");
  AST_ACCUM_LOAD: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_IDLE && start && op == OP_INC_ACCUM_SKIP)
      |=> (accumulator_reg == $past(mem_rdata) + 8'h01))
    else $error("Accumulator not loaded");
  AST_ACCUM_HOLD: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_IDLE && start && op != OP_INC_ACCUM_SKIP)
      |=> $stable(accumulator_reg))
    else $error("Accumulator changed by another operation");
  AST_ACCUM_NO_WR: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_IDLE && start && op != OP_INC_MEM_SKIP) |=> !mem_we)
    else $error("Unexpected memory write");
  AST_BIT_SET: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_IDLE && start && op == OP_BIT_SKIP && mem_rdata[bit_sel])
      |=> skip_next)
    else $error("Bit set did not skip");
  AST_BIT_CLR: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_IDLE && start && op == OP_BIT_SKIP && !mem_rdata[bit_sel])
      |=> !skip_next)
    else $error("Bit clear skipped");
  AST_SKIP_LEN: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_IDLE && start && skip) |=> !done ##1 dummy_cycle ##1 done)
    else $error("Skip did not take three cycles");
  AST_DUMMY_SKIP: assert property (
    @(posedge clk_sys) disable iff (rst)
    dummy_cycle |-> skip_next)
    else $error("Dummy cycle without a skip");
  AST_DONE_PULSE: assert property (
    @(posedge clk_sys) disable iff (rst)
    done |=> !done)
    else $error("Done longer than one cycle");
  AST_NO_FLAGS: assert property (
    @(posedge clk_sys) disable iff (rst)
    !flags_we)
    else $error("Flags written");
  AST_NORMAL_LEN: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_IDLE && start && !skip) |=> !done ##1 (done && !dummy_cycle))
    else $error("Normal length wrong");
  // One idle slot after done keeps back-to-back starts from overlapping
  AST_BACK_IDLE: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_DONE) |=> (state_reg == ST_IDLE && !busy))
    else $error("Did not return to idle after done");
endmodule
`default_nettype wire

//--- bench/mem_model.sv
// Data memory model facing the skip execution unit.
// Assumes the bench preloads bytes; reads are combinational.
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  input  wire logic       clk_sys,
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_waddr,
  input  wire logic [7:0] mem_wdata,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data
);
  logic [7:0] mem [256];
  // Operand must be valid in the start cycle itself
  assign rd_data = mem[rd_addr];
  always @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the skip execution unit.
// Assumes the package is compiled first and memory feeds mem_rdata.
`timescale 1ns/1ns
`include "skip_exec_cfg.svh"
`default_nettype none
module tb_top import skip_exec_pkg::*;;
  logic       clk_sys;
  logic       rst;
  logic       start;
  skip_op_e   op;
  logic [7:0] mem_addr;
  logic [7:0] mem_rdata;
  logic [2:0] bit_sel;
  logic       busy;
  logic       mem_we;
  logic [7:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] accumulator_reg;
  logic       skip_next;
  logic       dummy_cycle;
  logic       flags_we;
  logic       done;
  logic [7:0] accum_exp;
  int         err_total;
  int         tests_run;

  skip_exec i_dut (.clk_sys(clk_sys), .rst(rst), .start(start), .op(op),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .bit_sel(bit_sel),
    .busy(busy), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .accumulator_reg(accumulator_reg),
    .skip_next(skip_next), .dummy_cycle(dummy_cycle),
    .flags_we(flags_we), .done(done));
  mem_model i_mem (.clk_sys(clk_sys), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .rd_addr(mem_addr),
    .rd_data(mem_rdata));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  function automatic logic exp_skip(logic [1:0] o, logic [7:0] v,
                                    logic [2:0] b);
    case (o)
      2'h0, 2'h1: return (v + 8'h01) == 8'h00;
      2'h2: return v[b];
      default: return 1'b0;
    endcase
  endfunction

  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One instruction; the next may start right after done
  task automatic run(input logic [1:0] o, input logic [7:0] a,
                     input logic [2:0] b);
    logic [7:0] v;
    logic       sk;
    logic       we_s;
    logic       dm_s;
    logic       fw_s;
    logic       sk_s;
    logic       bz_s;
    int         k;
    v = i_mem.mem[a];
    sk = exp_skip(o, v, b);
    @(posedge clk_sys);
    start <= 1'b1;
    op <= skip_op_e'(o);
    mem_addr <= a;
    bit_sel <= b;
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    k = 1;
    we_s = mem_we;
    dm_s = dummy_cycle;
    fw_s = flags_we;
    sk_s = skip_next;
    bz_s = busy;
    while (done !== 1'b1 && k < 10) begin
      @(posedge clk_sys);
      #1;
      k++;
      we_s |= mem_we;
      dm_s |= dummy_cycle;
      fw_s |= flags_we;
      bz_s &= busy;
    end
    if (k >= 10) begin
      err_total++;
      test_done;
    end
    if (o == 2'h1) accum_exp = v + 8'h01;
    chk(8'(sk_s), 8'(sk));
    chk(8'(k), 8'(sk ? `SKIP_CYCLES : `NORMAL_CYCLES));
    chk(8'(bz_s), 8'h01);
    chk(8'(dm_s), 8'(sk));
    chk(8'(we_s), 8'(o == 2'h0));
    chk(8'(fw_s), 8'h00);
    chk(accumulator_reg, accum_exp);
    chk(i_mem.mem[a], (o == 2'h0) ? v + 8'h01 : v);
  endtask

  // ----------------------------------------
  // Clock and sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    accum_exp = `ACCUM_RESET;
    rst = 1'b1;
    start = 1'b0;
    op = OP_INC_MEM_SKIP;
    mem_addr = 8'h00;
    bit_sel = 3'h0;
    void'($urandom(22898));
    for (int i = 0; i < 256; i++) i_mem.mem[i] = 8'($urandom);
    i_mem.mem[1] = 8'hff;
    i_mem.mem[2] = 8'hfe;
    i_mem.mem[3] = 8'hff;
    i_mem.mem[4] = 8'h00;
    i_mem.mem[5] = 8'h5a;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // Wrap to zero, then the byte left at zero, then one short of wrap
    run(2'h0, 8'h01, 3'h0);
    run(2'h0, 8'h01, 3'h0);
    run(2'h0, 8'h02, 3'h0);
    run(2'h1, 8'h03, 3'h0);
    run(2'h1, 8'h04, 3'h0);
    run(2'h3, 8'h03, 3'h0);
    for (int b = 0; b < 8; b++) run(2'h2, 8'h05, 3'(b));
    repeat (60) run(2'($urandom_range(3)), 8'($urandom), 3'($urandom));
    test_done;
  end
endmodule
`default_nettype wire
